/* File: core/burst_sram_pkg.sv */
// shared constants for the two-word burst sram link
// Summary of operation
// - addresses taken on alternate strobe rising edges
// - write beats taken on both strobes' rises
// - read beats launched on both strobes' rises
// - one address carries a two-word burst
// - bypass high: first beat 2.5 cycles later
// - bypass low: one cycle read latency
// - read valid flag marks driven read beats
// - echo strobes travel aligned with read data
// - inputs and outputs registered on strobe edges
// - array writes are self-timed internally
// - only rising strobe edges carry timing
// - shared data bus, never driven by both
package burst_sram_pkg;
   localparam int DATA_W         = 18;
   localparam int ADDR_W         = 4;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int LINK_PERIOD_NS = 160;
   // one strobe period is four quarters of the divider
   localparam int QTR_CYCLES     = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
   // read latency counted in strobe half periods
   localparam int LAT_BYP_HALF   = 5;
   localparam int LAT_LEG_HALF   = 2;
   localparam int TOK_LEN        = 6;
   localparam int RDBUF_DEPTH    = 2;
   localparam logic [1:0] QTR_RESET   = 2'h2;
   localparam logic       PHASE_RESET = 1'h0;
   localparam logic       OEN_RESET   = 1'h1;
   localparam logic       LDN_RESET   = 1'h1;
endpackage

/* File: core/burst_link_if.sv */
// link between the memory controller and the burst sram
interface burst_link_if
   import burst_sram_pkg::*;
   #(parameter int DW = DATA_W,
     parameter int AW = ADDR_W);
   logic          strobe;
   logic          strobeN;
   logic          ldN;
   logic          rw;
   logic          pllBypassPin;
   logic [AW-1:0] addr;
   logic [DW-1:0] dqCtl;
   logic          ctlOeN;
   logic [DW-1:0] dqDev;
   logic          devOeN;
   logic [DW-1:0] dq;
   logic          echoStrobe;
   logic          echoStrobeN;
   logic          readValidFlag;
   // shared bus level: controller drive takes priority over sram drive, idle reads zero
   assign dq = !ctlOeN ? dqCtl : (!devOeN ? dqDev : '0);
   modport device (
      input  strobe, strobeN, ldN, rw, pllBypassPin, addr, dq,
      output dqDev, devOeN, echoStrobe, echoStrobeN, readValidFlag
   );
   modport ctrl (
      output strobe, strobeN, ldN, rw, pllBypassPin, addr, dqCtl,
      output ctlOeN,
      input  dq, echoStrobe, echoStrobeN, readValidFlag
   );
endinterface

/* File: core/burst_sram_device.sv */
// sram end of the link: sampling, array, read pipeline, echo strobes
module burst_sram_device
   import burst_sram_pkg::*;
   #(parameter int DW = DATA_W,
     parameter int AW = ADDR_W)
   (
   input  wire logic   mclk,
   input  wire logic   nrst,
   burst_link_if.device link,
   output logic        wrDone,
   output logic        rdBusy
   );

   localparam int SW = 5 + AW + DW;
   localparam int BW = 2 * DW;
   // idle pin levels, so no false edge follows reset
   localparam logic [SW-1:0] SYNC_IDLE = {1'b0, 1'b1, LDN_RESET, 1'b1,
                                          1'b0, {AW{1'b0}}, {DW{1'b0}}};

   // two-flop synchroniser for every pin from the controller
   logic [SW-1:0]  syncA_reg;
   logic [SW-1:0]  syncB_reg;
   wire  [SW-1:0]  pinsIn;

   assign pinsIn = {link.strobe, link.strobeN, link.ldN, link.rw,
                    link.pllBypassPin, link.addr, link.dq};

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         syncA_reg <= SYNC_IDLE;
         syncB_reg <= SYNC_IDLE;
      end else begin
         syncA_reg <= pinsIn;
         syncB_reg <= syncA_reg;
      end
   end

   wire           strobeS;
   wire           strobeNS;
   wire           ldNS;
   wire           rwS;
   wire           bypassS;
   wire [AW-1:0]  addrS;
   wire [DW-1:0]  dqS;

   assign {strobeS, strobeNS, ldNS, rwS, bypassS, addrS, dqS} =
      syncB_reg;

   // rising-edge detection only
   logic          strobeD_reg;
   logic          strobeND_reg;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         strobeD_reg  <= 1'h0;
         strobeND_reg <= 1'h1;
      end else begin
         strobeD_reg  <= strobeS;
         strobeND_reg <= strobeNS;
      end
   end

   wire strobeRise;
   wire strobeNRise;
   wire halfEdge;

   assign strobeRise  = strobeS & ~strobeD_reg;
   assign strobeNRise = strobeNS & ~strobeND_reg;
   assign halfEdge    = strobeRise | strobeNRise;

   // address slot alternates on each main strobe rise
   logic phase_reg;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         phase_reg <= PHASE_RESET;
      end else if (strobeRise) begin
         phase_reg <= ~phase_reg;
      end
   end

   wire accept;
   wire rdAccept;
   wire wrAccept;

   assign accept   = strobeRise & ~phase_reg & ~ldNS;
   assign rdAccept = accept & rwS;
   assign wrAccept = accept & ~rwS;

   // array storage: one two-word burst per address
   logic [BW-1:0] mem [2**AW];

   // write capture: low beat on complement rise, high on main rise
   logic          wrPend_reg;
   logic          wrHalf_reg;
   logic [AW-1:0] wrAddr_reg;
   logic [DW-1:0] wrLo_reg;
   logic [DW-1:0] wrHi_reg;
   logic          wrCommit_reg;

   wire wrBeat0;
   wire wrBeat1;

   assign wrBeat0 = strobeNRise & wrPend_reg & ~wrHalf_reg;
   assign wrBeat1 = strobeRise & wrHalf_reg;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wrPend_reg <= 1'h0;
         wrHalf_reg <= 1'h0;
      end else if (wrAccept) begin
         wrPend_reg <= 1'h1;
         wrHalf_reg <= 1'h0;
      end else if (wrBeat0) begin
         wrHalf_reg <= 1'h1;
      end else if (wrBeat1) begin
         wrPend_reg <= 1'h0;
         wrHalf_reg <= 1'h0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wrAddr_reg <= '0;
         wrLo_reg   <= '0;
         wrHi_reg   <= '0;
      end else begin
         if (wrAccept) begin
            wrAddr_reg <= addrS;
         end
         if (wrBeat0) begin
            wrLo_reg <= dqS;
         end
         if (wrBeat1) begin
            wrHi_reg <= dqS;
         end
      end
   end

   // self-timed array write one cycle after the last beat
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wrCommit_reg <= 1'h0;
      end else begin
         wrCommit_reg <= wrBeat1;
      end
   end

   always_ff @(posedge mclk) begin
      if (wrCommit_reg) begin
         mem[wrAddr_reg] <= {wrHi_reg, wrLo_reg};
      end
   end

   assign wrDone = wrCommit_reg;

   // read pipeline: tokens step on every half period
   logic [TOK_LEN-1:0] tok_reg;
   logic [BW-1:0]      slot_reg [2];
   logic               slotWr_reg;
   logic               slotRd_reg;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tok_reg <= '0;
      end else if (halfEdge) begin
         tok_reg <= {tok_reg[TOK_LEN-2:0], rdAccept};
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         slotWr_reg <= 1'h0;
      end else if (rdAccept) begin
         slotWr_reg <= ~slotWr_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (rdAccept) begin
         slot_reg[slotWr_reg] <= mem[addrS];
      end
   end

   wire rdBeat0;
   wire rdBeat1;
   wire rdBeat;

   assign rdBeat0 = halfEdge & (bypassS ? tok_reg[LAT_BYP_HALF-1]
                                        : tok_reg[LAT_LEG_HALF-1]);
   assign rdBeat1 = halfEdge & (bypassS ? tok_reg[LAT_BYP_HALF]
                                        : tok_reg[LAT_LEG_HALF]);
   assign rdBeat  = rdBeat0 | rdBeat1;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         slotRd_reg <= 1'h0;
      end else if (rdBeat1) begin
         slotRd_reg <= ~slotRd_reg;
      end
   end

   wire [BW-1:0] rdWord;
   wire [DW-1:0] rdSel;

   assign rdWord = slot_reg[slotRd_reg];
   assign rdSel  = rdBeat0 ? rdWord[DW-1:0] : rdWord[BW-1:DW];

   // output registers launched on half-period edges
   logic [DW-1:0] dqOut_reg;
   logic          oeN_reg;
   logic          valid_reg;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dqOut_reg <= '0;
      end else if (rdBeat) begin
         dqOut_reg <= rdSel;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         oeN_reg   <= OEN_RESET;
         valid_reg <= 1'h0;
      end else if (halfEdge) begin
         oeN_reg   <= ~rdBeat;
         valid_reg <= rdBeat;
      end
   end

   // echo strobes follow the sampled strobes with the data's delay
   logic echo_reg;
   logic echoN_reg;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         echo_reg  <= 1'h0;
         echoN_reg <= 1'h1;
      end else begin
         echo_reg  <= strobeS;
         echoN_reg <= strobeNS;
      end
   end

   assign link.dqDev         = dqOut_reg;
   assign link.devOeN        = oeN_reg;
   assign link.readValidFlag = valid_reg;
   assign link.echoStrobe    = echo_reg;
   assign link.echoStrobeN   = echoN_reg;
   assign rdBusy             = (|tok_reg) | valid_reg;

endmodule

/* File: core/burst_sram_ctrl.sv */
// controller end: strobe divider, command sequencer, read buffer
module burst_sram_ctrl
   import burst_sram_pkg::*;
   #(parameter int DW    = DATA_W,
     parameter int AW    = ADDR_W,
     parameter int QTR   = QTR_CYCLES,
     parameter int DEPTH = RDBUF_DEPTH)
   (
   input  wire logic          mclk,
   input  wire logic          nrst,
   burst_link_if.ctrl         link,
   input  wire logic          bypassSel,
   input  wire logic          cmdValid,
   output logic               cmdReady,
   input  wire logic          cmdRead,
   input  wire logic [AW-1:0] cmdAddr,
   input  wire logic [2*DW-1:0] cmdData,
   output logic               rdValid,
   input  wire logic          rdReady,
   output logic [2*DW-1:0]    rdData
   );

   localparam int BW = 2 * DW;
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef enum logic [3:0] {
      IDLE  = 4'h1,
      ISSUE = 4'h2,
      WBEAT = 4'h4,
      RWAIT = 4'h8
   } state_t;

   // divider: four quarters make one strobe period
   logic [7:0] qCnt_reg;
   logic [1:0] q_reg;
   logic       kPh_reg;
   logic       stb_reg;
   logic       stbN_reg;

   wire       qTick;
   wire [1:0] qNext;
   wire       enterQ0;
   wire       enterQ1;
   wire       enterQ3;

   assign qTick   = (qCnt_reg == 8'(QTR - 1));
   assign qNext   = q_reg + 2'h1;
   assign enterQ0 = qTick & (q_reg == 2'h3);
   assign enterQ1 = qTick & (q_reg == 2'h0);
   assign enterQ3 = qTick & (q_reg == 2'h2);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         qCnt_reg <= '0;
         q_reg    <= QTR_RESET;
         stb_reg  <= 1'h0;
         stbN_reg <= 1'h1;
      end else begin
         qCnt_reg <= qTick ? 8'h00 : qCnt_reg + 8'h01;
         if (qTick) begin
            q_reg    <= qNext;
            stb_reg  <= ~qNext[1];
            stbN_reg <= qNext[1];
         end
      end
   end

   // parity of main strobe rises, matches the sram's slot
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         kPh_reg <= PHASE_RESET;
      end else if (enterQ0) begin
         kPh_reg <= ~kPh_reg;
      end
   end

   // read return sampled through two flops
   localparam int RW = 3 + DW;
   // idle return levels: complement echo rests high
   localparam logic [RW-1:0] RS_IDLE = {1'b0, 1'b1, 1'b0, {DW{1'b0}}};
   logic [RW-1:0] rsA_reg;
   logic [RW-1:0] rsB_reg;
   logic          cqD_reg;
   logic          cqND_reg;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rsA_reg  <= RS_IDLE;
         rsB_reg  <= RS_IDLE;
         cqD_reg  <= 1'h0;
         cqND_reg <= 1'h1;
      end else begin
         rsA_reg  <= {link.echoStrobe, link.echoStrobeN,
                      link.readValidFlag, link.dq};
         rsB_reg  <= rsA_reg;
         cqD_reg  <= rsB_reg[RW-1];
         cqND_reg <= rsB_reg[RW-2];
      end
   end

   wire          capEdge;
   wire [DW-1:0] dqS;

   assign capEdge = (rsB_reg[RW-1] & ~cqD_reg) | (rsB_reg[RW-2] & ~cqND_reg);
   assign dqS     = rsB_reg[DW-1:0];

   // read buffer
   logic [BW-1:0] buf_reg [DEPTH];
   logic [PW-1:0] wPtr_reg;
   logic [PW-1:0] rPtr_reg;
   logic [PW:0]   cnt_reg;
   logic          push;
   logic [DW-1:0] rLo_reg;
   logic          rHalf_reg;
   state_t        state_reg;

   wire pop;
   wire full;

   assign full    = (cnt_reg == (PW+1)'(DEPTH));
   assign rdValid = (cnt_reg != '0);
   assign pop     = rdValid & rdReady;
   assign rdData  = buf_reg[rPtr_reg];
   assign push    = (state_reg == RWAIT) & capEdge & rsB_reg[RW-3]
                    & rHalf_reg;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wPtr_reg <= '0;
         rPtr_reg <= '0;
         cnt_reg  <= '0;
      end else begin
         if (push) begin
            wPtr_reg <= (wPtr_reg == PW'(DEPTH - 1)) ? '0 : wPtr_reg + 1'b1;
         end
         if (pop) begin
            rPtr_reg <= (rPtr_reg == PW'(DEPTH - 1)) ? '0 : rPtr_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         buf_reg[wPtr_reg] <= {dqS, rLo_reg};
      end
   end

   // command sequencer
   logic [BW-1:0] wData_reg;
   logic          wSecond_reg;
   logic          ldN_reg;
   logic          rw_reg;
   logic [AW-1:0] addr_reg;
   logic [DW-1:0] dqOut_reg;
   logic          oeN_reg;
   logic          byp_reg;

   assign cmdReady = (state_reg == IDLE) & enterQ3 & ~kPh_reg & ~full;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg   <= IDLE;
         ldN_reg     <= LDN_RESET;
         rw_reg      <= 1'h1;
         addr_reg    <= '0;
         wData_reg   <= '0;
         dqOut_reg   <= '0;
         oeN_reg     <= OEN_RESET;
         wSecond_reg <= 1'h0;
         rHalf_reg   <= 1'h0;
         rLo_reg     <= '0;
      end else begin
         unique case (state_reg)
            IDLE: if (cmdValid & cmdReady) begin
               ldN_reg   <= 1'h0;
               rw_reg    <= cmdRead;
               addr_reg  <= cmdAddr;
               wData_reg <= cmdData;
               state_reg <= ISSUE;
            end
            ISSUE: if (enterQ1) begin
               ldN_reg     <= 1'h1;
               rHalf_reg   <= 1'h0;
               wSecond_reg <= 1'h0;
               if (!rw_reg) begin
                  dqOut_reg <= wData_reg[DW-1:0];
                  oeN_reg   <= 1'h0;
                  state_reg <= WBEAT;
               end else begin
                  state_reg <= RWAIT;
               end
            end
            WBEAT: if (enterQ3 & ~wSecond_reg) begin
               dqOut_reg   <= wData_reg[BW-1:DW];
               wSecond_reg <= 1'h1;
            end else if (enterQ1 & wSecond_reg) begin
               oeN_reg   <= 1'h1;
               state_reg <= IDLE;
            end
            RWAIT: if (capEdge & rsB_reg[RW-3]) begin
               if (!rHalf_reg) begin
                  rLo_reg   <= dqS;
                  rHalf_reg <= 1'h1;
               end else begin
                  state_reg <= IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         byp_reg <= 1'h0;
      end else begin
         byp_reg <= bypassSel;
      end
   end

   assign link.strobe       = stb_reg;
   assign link.strobeN      = stbN_reg;
   assign link.ldN          = ldN_reg;
   assign link.rw           = rw_reg;
   assign link.addr         = addr_reg;
   assign link.dqCtl        = dqOut_reg;
   assign link.ctlOeN       = oeN_reg;
   assign link.pllBypassPin = byp_reg;

endmodule

/* File: bench/burst_sram_asserts.sv */
// concurrent checks on the link between controller and sram ends
module burst_sram_asserts
   import burst_sram_pkg::*;
   #(parameter int AW  = ADDR_W,
     parameter int QTR = QTR_CYCLES)
   (
   input wire logic          mclk,
   input wire logic          nrst,
   input wire logic          strobe,
   input wire logic          strobeN,
   input wire logic          ldN,
   input wire logic          rw,
   input wire logic          pllBypassPin,
   input wire logic [AW-1:0] addr,
   input wire logic          ctlOeN,
   input wire logic          devOeN,
   input wire logic          readValidFlag,
   input wire logic          echoStrobe,
   input wire logic          echoStrobeN
   );
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BYP_MIN = 10 * QTR;
   localparam int BYP_MAX = 10 * QTR + 6;
   localparam int LEG_MIN = 4 * QTR;
   localparam int LEG_MAX = 4 * QTR + 6;
   localparam int BURST_LEN = 4 * QTR;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   int vldLen_reg;
   int vldLen_next;
   int oeLen_reg;
   int oeLen_next;

   // length of the current read-valid and write-drive stretches
   assign vldLen_next = readValidFlag ? vldLen_reg + 1 : 0;
   assign oeLen_next  = !ctlOeN ? oeLen_reg + 1 : 0;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         vldLen_reg <= 0;
         oeLen_reg  <= 0;
      end else begin
         vldLen_reg <= vldLen_next;
         oeLen_reg  <= oeLen_next;
      end
   end

   sequence addrHeld;
      !ldN && $stable(addr) && $stable(rw);
   endsequence
   sequence rdAddr;
      $rose(strobe) && !ldN && rw;
   endsequence

   strobe_pair_a: assert property (strobeN == !strobe)
      else $error("strobe pair not complementary");
   bus_excl_a: assert property (ctlOeN || devOeN)
      else $error("both ends drive the data bus");
   // counts assume four mclk cycles per strobe quarter
   addr_load_a: assert property ($fell(ldN) |-> ##1 addrHeld[*3]
      ##1 (addrHeld and $rose(strobe)) ##1 addrHeld[*3] ##1 ldN)
      else $error("address not held across one strobe rise");
   wr_start_a: assert property ($fell(ctlOeN) |-> $rose(ldN))
      else $error("write drive not started after address");
   wr_len_a: assert property ($rose(ctlOeN) |-> oeLen_reg == BURST_LEN)
      else $error("write drive length wrong");
   byp_lat_a: assert property (rdAddr and pllBypassPin
      |-> ##[BYP_MIN:BYP_MAX] $rose(readValidFlag))
      else $error("bypass read latency wrong");
   leg_lat_a: assert property (rdAddr and !pllBypassPin
      |-> ##[LEG_MIN:LEG_MAX] $rose(readValidFlag))
      else $error("legacy read latency wrong");
   vld_len_a: assert property ($fell(readValidFlag)
      |-> vldLen_reg == BURST_LEN)
      else $error("read valid length wrong");
   vld_drive_a: assert property (readValidFlag |-> !devOeN)
      else $error("read valid without driven data");
   echo_align_a: assert property ($fell(devOeN)
      |-> $rose(echoStrobe) || $rose(echoStrobeN))
      else $error("read data not launched with echo strobe");
endmodule

/* File: bench/burst_sram_interface_tb_top.sv */
// self-checking bench for the controller and sram ends joined by the link
`define CHECK(got, exp, msg) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("CHECK FAILED at %0t: %s", $time, msg); \
      end \
   end

module burst_sram_interface_tb_top
   import burst_sram_pkg::*;
   ();
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DW = DATA_W;
   localparam int AW = ADDR_W;
   localparam int TMAX = 20000;

   logic            mclk;
   logic            nrst;
   logic            bypassSel;
   logic            cmdValid;
   logic            cmdReady;
   logic            cmdRead;
   logic [AW-1:0]   cmdAddr;
   logic [2*DW-1:0] cmdData;
   logic            rdValid;
   logic            rdReady;
   logic [2*DW-1:0] rdData;
   logic            wrDone;
   logic            rdBusy;
   int              num_errors;
   int              n_compared;
   int              cycles;

   burst_link_if link ();

   burst_sram_device u_burst_sram_device (
      .mclk(mclk), .nrst(nrst), .link(link.device),
      .wrDone(wrDone), .rdBusy(rdBusy));

   burst_sram_ctrl u_burst_sram_ctrl (
      .mclk(mclk), .nrst(nrst), .link(link.ctrl), .bypassSel(bypassSel),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead),
      .cmdAddr(cmdAddr), .cmdData(cmdData), .rdValid(rdValid),
      .rdReady(rdReady), .rdData(rdData));

   burst_sram_asserts u_burst_sram_asserts (
      .mclk(mclk), .nrst(nrst), .strobe(link.strobe),
      .strobeN(link.strobeN), .ldN(link.ldN), .rw(link.rw),
      .pllBypassPin(link.pllBypassPin), .addr(link.addr),
      .ctlOeN(link.ctlOeN), .devOeN(link.devOeN),
      .readValidFlag(link.readValidFlag), .echoStrobe(link.echoStrobe),
      .echoStrobeN(link.echoStrobeN));

   always #5 mclk = ~mclk;

   task automatic summarize();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == TMAX) begin
         num_errors++;
         summarize();
      end
   end

   task automatic do_reset(input logic byp);
      nrst = 1'b0;
      bypassSel = byp;
      repeat (4) @(posedge mclk);
      #1 nrst = 1'b1;
   endtask

   // offer one command; ok tells whether it was taken within nmax edges
   task automatic send_cmd(input logic rd, input logic [AW-1:0] a,
                           input logic [2*DW-1:0] d, input int nmax,
                           output logic ok);
      int n;
      n = 0;
      @(posedge mclk);
      #1;
      cmdRead = rd;
      cmdAddr = a;
      cmdData = d;
      cmdValid = 1'b1;
      // cmdReady is looked at once settled; the next edge takes it
      while (cmdReady !== 1'b1 && n < nmax) begin
         @(posedge mclk);
         #1;
         n++;
      end
      ok = (cmdReady === 1'b1);
      @(posedge mclk);
      #1 cmdValid = 1'b0;
   endtask

   task automatic do_write(input logic [AW-1:0] a, input logic [2*DW-1:0] d);
      logic ok;
      int n;
      send_cmd(1'b0, a, d, 200, ok);
      `CHECK(ok, 1'b1, "write not taken")
      @(posedge link.strobeN);
      `CHECK(link.dq, d[DW-1:0], "low write word")
      @(posedge link.strobe);
      `CHECK(link.dq, d[2*DW-1:DW], "high write word")
      n = 0;
      while (wrDone !== 1'b1 && n < 100) begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHECK(wrDone, 1'b1, "array write not committed")
   endtask

   task automatic issue_read(input logic [AW-1:0] a);
      logic ok;
      send_cmd(1'b1, a, '0, 200, ok);
      `CHECK(ok, 1'b1, "read not taken")
      repeat (8) @(posedge mclk);
      #1;
      `CHECK(rdBusy, 1'b1, "read not in pipeline")
   endtask

   task automatic get_read(input logic [2*DW-1:0] exp);
      int n;
      n = 0;
      // always let one edge pass so rdReady is never set twice at once
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (rdValid !== 1'b1 && n < 200);
      `CHECK(rdData, exp, "read burst data")
      rdReady = 1'b1;
      @(posedge mclk);
      #1 rdReady = 1'b0;
   endtask

   task automatic test_idle();
      `CHECK(link.dq, '0, "idle bus not released")
      `CHECK(rdValid, 1'b0, "read data after reset")
   endtask

   // boundary addresses and patterns, read back in the slow mode
   task automatic test_rw_bypass();
      logic [AW-1:0]   a [3];
      logic [2*DW-1:0] d [3];
      a = '{4'h0, 4'h5, 4'hf};
      d = '{36'h0_0001_3fff, 36'hf_ffff_0000, 36'ha_5a5a_5a5a};
      for (int i = 0; i < 3; i++) do_write(a[i], d[i]);
      for (int i = 2; i >= 0; i--) begin
         issue_read(a[i]);
         get_read(d[i]);
      end
   endtask

   // two unread bursts fill the buffer; a third read must wait
   task automatic test_buffer_full();
      logic ok;
      issue_read(4'h0);
      issue_read(4'hf);
      send_cmd(1'b1, 4'h5, '0, 80, ok);
      `CHECK(ok, 1'b0, "read taken while buffer full")
      get_read(36'h0_0001_3fff);
      get_read(36'ha_5a5a_5a5a);
      @(posedge mclk);
      #1;
      `CHECK(rdValid, 1'b0, "buffer not empty after drain")
   endtask

   // second reset into the one-cycle latency mode
   task automatic test_legacy();
      do_reset(1'b0);
      test_idle();
      do_write(4'h3, 36'h1_2345_6789);
      do_write(4'h4, 36'he_dcba_9876);
      issue_read(4'h3);
      get_read(36'h1_2345_6789);
      issue_read(4'h4);
      get_read(36'he_dcba_9876);
   endtask

   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      bypassSel = 1'b1;
      cmdValid = 1'b0;
      cmdRead = 1'b0;
      cmdAddr = '0;
      cmdData = '0;
      rdReady = 1'b0;
      num_errors = 0;
      n_compared = 0;
      cycles = 0;
      do_reset(1'b1);
      test_idle();
      test_rw_bypass();
      test_buffer_full();
      test_legacy();
      repeat (20) @(posedge mclk);
      summarize();
   end
endmodule
